// ==== core/protect_bank_pkg.sv ====
// Package: register map, field layout and reset values of the write-protect bank
package protect_bank_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PROTECT_CLEAR_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PROTECT_SET_OFS = 8'h04;
  localparam logic [DATA_W-1:0] PROTECT_RESET = 32'h00800000;
  // Bits that hold a protect flag: 23 (reset-set), 19..16, 15..8, 7..1
  localparam logic [DATA_W-1:0] PROTECT_MASK = 32'h008FFFFE;
  localparam int TOUCH_BIT = 19;
  localparam int ANALOG_LSB = 16;
  localparam int ANALOG_N = 4;
  localparam int TIMER_LSB = 8;
  localparam int TIMER_N = 8;
  localparam int SERIAL_LSB = 2;
  localparam int SERIAL_N = 6;
  localparam int EVENT_BIT = 1;
endpackage

// ==== core/protect_bit_cell.sv ====
// One protect flag with write-one-to-clear and write-one-to-set inputs
`timescale 1ns/10ps
`default_nettype none
module protect_bit_cell
  import protect_bank_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic set_i,
  output logic prot_o
);
  logic prot_reg;
  logic prot_next;

  // Zero writes leave the flag alone; set wins when both strobes land together
  always_comb
  begin
    prot_next = prot_reg;
    if (clear_i)
    begin
      prot_next = 1'b0;
    end
    if (set_i)
    begin
      prot_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prot_reg <= RESET_VAL;
    end
    else
    begin
      prot_reg <= prot_next;
    end
  end

  assign prot_o = prot_reg;
endmodule
`default_nettype wire

// ==== core/reg_read_mux.sv ====
// Registered read-data path for the protect bank
`timescale 1ns/10ps
`default_nettype none
module reg_read_mux
  import protect_bank_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] state_i,
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] rdata_reg;

  // Both offsets read the same protection state; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 32'h00000000;
    end
    else if (rd_i && (addr_i == PROTECT_CLEAR_OFS || addr_i == PROTECT_SET_OFS))
    begin
      rdata_reg <= state_i;
    end
    else
    begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ==== core/peripheral_write_protect_bank.sv ====
// Top: peripheral write-protect bank with clear/set registers and per-peripheral enables
// Functional notes
// - Writing 0 to a protect bit in either register leaves it unchanged.
// - Writing 1 to a clear-register bit removes that peripheral's protection; 1 reads protected.
// - Clear register at offset 0x00, 32 bits, resets 0x00800000; bits 19..16 analog/touch.
// - Set register at 0x04, same layout and reset, reads same state.
// - Bits 15..8 protect timer instances 7..0.
// - Bits 7..2 protect serial units 5..0; bit 1 event system.
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect_bank
  import protect_bank_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  output logic [TIMER_N-1:0] TIMER_INSTANCE_BITS_O,
  output logic [SERIAL_N-1:0] SERIAL_UNIT_BITS_O,
  output logic EVENT_SYSTEM_BIT_O,
  output logic [ANALOG_N-1:0] ANALOG_BITS_O,
  output logic TOUCH_CONTROLLER_BIT_O
);
  logic wr_clear;
  logic wr_set;
  logic [DATA_W-1:0] prot_state;
  logic [DATA_W-1:0] clear_mask;
  logic [DATA_W-1:0] set_mask;
  logic addr_mapped;
  logic rd_hit_reg;

  assign wr_clear = WR_I && (ADDR_I == PROTECT_CLEAR_OFS);
  assign wr_set = WR_I && (ADDR_I == PROTECT_SET_OFS);
  assign addr_mapped = (ADDR_I == PROTECT_CLEAR_OFS) || (ADDR_I == PROTECT_SET_OFS);

  // Only ones that land on a protect flag reach a cell
  assign clear_mask = WDATA_I & PROTECT_MASK & {DATA_W{wr_clear}};
  assign set_mask = WDATA_I & PROTECT_MASK & {DATA_W{wr_set}};

  genvar b;
  generate
    for (b = 0; b < DATA_W; b++)
    begin : g_bit
      if (PROTECT_MASK[b])
      begin : g_cell
        protect_bit_cell #(
          .RESET_VAL(PROTECT_RESET[b])
        ) u_cell (
          .clk_i(CLK_I),
          .rst_n_i(RST_N_I),
          .clear_i(clear_mask[b]),
          .set_i(set_mask[b]),
          .prot_o(prot_state[b])
        );
      end
      else
      begin : g_rsvd
        assign prot_state[b] = 1'b0;
      end
    end
  endgenerate

  reg_read_mux u_rd (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .rd_i(RD_I),
    .addr_i(ADDR_I),
    .state_i(prot_state),
    .rdata_o(RDATA_O)
  );

  // Marks the cycle in which read data stand; elsewhere the read port must be zero
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      rd_hit_reg <= 1'b0;
    end
    else
    begin
      rd_hit_reg <= RD_I && addr_mapped;
    end
  end

  assign TIMER_INSTANCE_BITS_O = prot_state[TIMER_LSB +: TIMER_N];
  assign SERIAL_UNIT_BITS_O = prot_state[SERIAL_LSB +: SERIAL_N];
  assign EVENT_SYSTEM_BIT_O = prot_state[EVENT_BIT];
  assign ANALOG_BITS_O = prot_state[ANALOG_LSB +: ANALOG_N];
  assign TOUCH_CONTROLLER_BIT_O = prot_state[TOUCH_BIT];

  // Assertions
  zero_write_keeps_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (WR_I && WDATA_I == 32'h00000000) |=> $stable(prot_state))
    else $error("zero write changed protection");
  clear_removes_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_clear && WDATA_I[TIMER_LSB]) |=> !TIMER_INSTANCE_BITS_O[0])
    else $error("clear write did not remove protection");
  set_enables_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_set && WDATA_I[SERIAL_LSB]) |=> SERIAL_UNIT_BITS_O[0])
    else $error("set write did not enable protection");
  reset_value_a: assert property (@(posedge CLK_I)
    $rose(RST_N_I) |-> (prot_state == PROTECT_RESET))
    else $error("reset value wrong");
  read_back_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (RD_I && (ADDR_I == PROTECT_SET_OFS) && !WR_I) |=> (RDATA_O == $past(prot_state)))
    else $error("set register read mismatch");
  reserved_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (RDATA_O & ~PROTECT_MASK) == 32'h00000000)
    else $error("reserved bit nonzero");
  timer_map_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_set && WDATA_I[15]) |=> TIMER_INSTANCE_BITS_O[7])
    else $error("timer bit mapping wrong");
  event_map_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_clear && WDATA_I[EVENT_BIT]) |=> !EVENT_SYSTEM_BIT_O)
    else $error("event bit mapping wrong");

  // Clear register, field by field
  clear_timer_top_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_clear && WDATA_I[TIMER_LSB + TIMER_N - 1])
    |=> !TIMER_INSTANCE_BITS_O[TIMER_N - 1]
  ) else $error("top timer bit not cleared");

  clear_serial_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_clear && WDATA_I[SERIAL_LSB])
    |=> !SERIAL_UNIT_BITS_O[0]
  ) else $error("low serial bit not cleared");

  clear_serial_top_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_clear && WDATA_I[SERIAL_LSB + SERIAL_N - 1])
    |=> !SERIAL_UNIT_BITS_O[SERIAL_N - 1]
  ) else $error("top serial bit not cleared");

  clear_analog_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_clear && WDATA_I[ANALOG_LSB])
    |=> !ANALOG_BITS_O[0]
  ) else $error("analog bit not cleared");

  clear_touch_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_clear && WDATA_I[TOUCH_BIT])
    |=> !TOUCH_CONTROLLER_BIT_O
  ) else $error("touch bit not cleared");

  clear_word_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    wr_clear
    |=> ((prot_state & $past(clear_mask)) == 32'h00000000)
  ) else $error("cleared flags still set");

  // Set register, field by field
  set_timer_low_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_set && WDATA_I[TIMER_LSB])
    |=> TIMER_INSTANCE_BITS_O[0]
  ) else $error("low timer bit not set");

  set_serial_top_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_set && WDATA_I[SERIAL_LSB + SERIAL_N - 1])
    |=> SERIAL_UNIT_BITS_O[SERIAL_N - 1]
  ) else $error("top serial bit not set");

  set_event_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_set && WDATA_I[EVENT_BIT])
    |=> EVENT_SYSTEM_BIT_O
  ) else $error("event bit not set");

  set_analog_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_set && WDATA_I[ANALOG_LSB])
    |=> ANALOG_BITS_O[0]
  ) else $error("analog bit not set");

  set_touch_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_set && WDATA_I[TOUCH_BIT])
    |=> TOUCH_CONTROLLER_BIT_O
  ) else $error("touch bit not set");

  set_word_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    wr_set
    |=> ((prot_state & $past(set_mask)) == $past(set_mask))
  ) else $error("set flags not all set");

  // Zero bits and idle cycles leave the flags alone
  clear_keeps_rest_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    wr_clear
    |=> ((prot_state & ~$past(clear_mask)) == ($past(prot_state) & ~$past(clear_mask)))
  ) else $error("clear write touched a zero bit");

  set_keeps_rest_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    wr_set
    |=> ((prot_state | $past(set_mask)) == ($past(prot_state) | $past(set_mask)))
  ) else $error("set write touched a zero bit");

  zero_clear_timer_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_clear && !WDATA_I[TIMER_LSB])
    |=> (TIMER_INSTANCE_BITS_O[0] == $past(TIMER_INSTANCE_BITS_O[0]))
  ) else $error("zero clear changed timer bit");

  zero_set_timer_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (wr_set && !WDATA_I[TIMER_LSB])
    |=> (TIMER_INSTANCE_BITS_O[0] == $past(TIMER_INSTANCE_BITS_O[0]))
  ) else $error("zero set changed timer bit");

  idle_keeps_state_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    !WR_I
    |=> $stable(prot_state)
  ) else $error("state changed without a write");

  unmapped_write_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (WR_I && !addr_mapped)
    |=> $stable(prot_state)
  ) else $error("unmapped write changed state");

  // Reset loads the documented word and quiets every output
  reset_load_a: assert property (
    @(posedge CLK_I)
    !RST_N_I
    |=> (prot_state == PROTECT_RESET)
  ) else $error("reset did not load state");

  reset_enables_a: assert property (
    @(posedge CLK_I)
    !RST_N_I
    |=> (!(|TIMER_INSTANCE_BITS_O) && !(|SERIAL_UNIT_BITS_O) && !EVENT_SYSTEM_BIT_O && !(|ANALOG_BITS_O) && !TOUCH_CONTROLLER_BIT_O)
  ) else $error("enable outputs not zero after reset");

  reset_rdata_a: assert property (
    @(posedge CLK_I)
    !RST_N_I
    |=> (RDATA_O == 32'h00000000)
  ) else $error("read data not zero after reset");

  // Read port
  read_clear_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (RD_I && (ADDR_I == PROTECT_CLEAR_OFS))
    |=> (RDATA_O == $past(prot_state))
  ) else $error("clear register read mismatch");

  read_idle_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    !rd_hit_reg
    |-> (RDATA_O == 32'h00000000)
  ) else $error("read data outside read cycle");

  read_unmapped_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (RD_I && !addr_mapped)
    |=> (RDATA_O == 32'h00000000)
  ) else $error("unmapped read not zero");

  read_timer_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (RD_I && addr_mapped)
    |=> (RDATA_O[TIMER_LSB +: TIMER_N] == $past(TIMER_INSTANCE_BITS_O))
  ) else $error("timer field read mismatch");

  read_serial_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (RD_I && addr_mapped)
    |=> ((RDATA_O[SERIAL_LSB +: SERIAL_N] == $past(SERIAL_UNIT_BITS_O)) && (RDATA_O[EVENT_BIT] == $past(EVENT_SYSTEM_BIT_O)))
  ) else $error("serial or event field read mismatch");

  read_analog_a: assert property (
    @(posedge CLK_I)
    disable iff (!RST_N_I)
    (RD_I && addr_mapped)
    |=> (RDATA_O[ANALOG_LSB +: ANALOG_N] == $past(ANALOG_BITS_O))
  ) else $error("analog field read mismatch");
endmodule
`default_nettype wire

// ==== tb/peripheral_write_protect_bank_tb.sv ====
// Testbench: register accesses and enable outputs of the write-protect bank
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect_bank_tb
  import protect_bank_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [TIMER_N-1:0] tim;
  logic [SERIAL_N-1:0] ser;
  logic [ANALOG_N-1:0] ana;
  logic evt;
  logic tch;
  int error_cnt = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  peripheral_write_protect_bank peripheral_write_protect_bank_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .TIMER_INSTANCE_BITS_O(tim), .SERIAL_UNIT_BITS_O(ser),
    .EVENT_SYSTEM_BIT_O(evt), .ANALOG_BITS_O(ana), .TOUCH_CONTROLLER_BIT_O(tch));
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_rd(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_en(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_rd("rdata", e, rdata);
  endtask
  // Both registers read the same state; enables mirror bits 19..1
  task automatic state(input logic [DATA_W-1:0] e);
    rd_reg(PROTECT_CLEAR_OFS, e);
    rd_reg(PROTECT_SET_OFS, e);
    chk_en("enables", {12'h000, e[19], e[19:1]},
      {12'h000, tch, ana, tim, ser, evt});
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    state(PROTECT_RESET);
    wr_reg(PROTECT_SET_OFS, 32'h000FFFFE);
    state(32'h008FFFFE);
    wr_reg(PROTECT_CLEAR_OFS, 32'h00000100);
    state(32'h008FFEFE);
    wr_reg(PROTECT_CLEAR_OFS, 32'h00000000);
    wr_reg(PROTECT_SET_OFS, 32'h00000000);
    state(32'h008FFEFE);
    wr_reg(PROTECT_CLEAR_OFS, 32'hFFFFFFFF);
    state(32'h00000000);
    wr_reg(PROTECT_SET_OFS, 32'h00080084);
    wr_reg(8'h08, 32'hFFFFFFFF);
    state(32'h00080084);
    rd_reg(8'h08, 32'h00000000);
    // Mid-run reset must restore the reset word
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    state(PROTECT_RESET);
    wrap_up();
  end
endmodule
`default_nettype wire
